// ---- src/pll_cfg_pkg.sv ----
// Function
// - Two-bit field selects one of three modes.
// - Output divider ratio limited to 2..2046.
// - Codes 0-2 give 2, 3-5 own, then even.
// - Synthesizer mode doubles reference, upper loop only.
// - Upper loop offers fractional or integer division.
// - High-bandwidth mode pre-divides input, upper loop.
// - Low-bandwidth mode uses lower loop divider.
// - Lock follows frequency lock, drops on loss.
// - Three feedback edges without reference raise fault.
// - Input fault uses mode-selected feedback edges.
// - Alarms run identically in every mode, except the input fault's feedback choice.
// - Input loss freezes phase except in synthesizer mode: holdover or free-run.
// - Register bit picks LVDS or LVPECL output.
// - Output driven only while enable bit set.
// - Slave address 11011 plus two fixed bits.
// - Block write: address, register, data, stop.
// - Register pointer autoincrements, bytes MSB first.
// - Block read uses repeated start, read bit.
// - Master stops after any byte, ideally 23.
// - Four independent instances, each own address.
// - Defaults load at reset, writable any time.
package pll_cfg_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int SCL_HZ = 100_000;
    localparam logic [7:0] SCL_QTR_CYC = 8'(CLK_HZ / (4 * SCL_HZ));
    localparam int REG_COUNT = 24;
    localparam logic [7:0] REG_STATUS = 8'h17;
    localparam logic [7:0] REG_LAST = 8'h17;
    localparam logic [4:0] ADDR_HI = 5'h1b;
    localparam logic [1:0] MISS_LIMIT = 2'h3;
    localparam int R_FRAC_HI = 0, R_FRAC_MID = 2, R_FRAC_LO = 4, R_INT_LO = 6, R_PDIV = 8;
    localparam int R_PDIV_LO = 10, R_LDIV = 12, R_LDIV_LO = 14, R_NDIV_LO = 16;
    localparam int R_OUTCFG = 18, R_MODE = 20, R_REFCFG = 22;
    localparam int QTYPE_BIT = 0, OE_BIT = 2, DBL_BIT = 3, DSM_BIT = 3;
    localparam int ST_HOLD_BIT = 6, ST_CLK_BIT = 4, ST_REF_BIT = 3, ST_LOCK_BIT = 2;
    localparam logic [23:0][7:0] REG_WMASK = {8'h00, 8'h08, 8'h0f, 8'hc4, 8'h00, 8'hfd,
        8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff,
        8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff, 8'h00, 8'hff};
    localparam logic [23:0][7:0] REG_DEFAULT = {8'h00, 8'ha1, 8'h60, 8'h10, {20{8'h00}}};

    typedef enum logic [1:0] {
        MODE_LB  = 2'h0,
        MODE_SYN = 2'h1,
        MODE_HB  = 2'h2,
        MODE_HB2 = 2'h3
    } mode_type;

    typedef struct packed {
        mode_type    mode;
        logic [10:0] out_ratio;
        logic [16:0] pre_div;
        logic [16:0] lower_loop_divider;
        logic [7:0]  fb_int;
        logic [17:0] fb_frac;
        logic [6:0]  bw;
        logic        frac_en;
        logic        ref_double;
        logic        use_upper_in;
        logic        lower_loop_en;
        logic        drv_en;
        logic        lvds_sel;
    } cfg_type;

    function automatic logic [10:0] div_ratio(input logic [10:0] code);
        if (code < 11'h3) begin
            return 11'h2;
        end
        if (code < 11'h6) begin
            return code;
        end
        return {code[10:1], 1'b0};
    endfunction : div_ratio

    function automatic cfg_type cfg_of(input logic [23:0][7:0] r);
        cfg_type c;
        c = '0;
        c.mode = mode_type'(r[R_MODE][7:6]);
        c.out_ratio = div_ratio({r[R_LDIV_LO][3:0], r[R_NDIV_LO][7:1]});
        c.fb_frac = {r[R_FRAC_HI], r[R_FRAC_MID], r[R_FRAC_LO][7:6]};
        c.fb_int = {r[R_FRAC_LO][5:0], r[R_INT_LO][7:6]};
        c.pre_div = {r[R_INT_LO][5:0], r[R_PDIV], r[R_PDIV_LO][7:5]};
        c.lower_loop_divider = {r[R_PDIV_LO][4:0], r[R_LDIV], r[R_LDIV_LO][7:4]};
        c.bw = {r[R_NDIV_LO][0], r[R_OUTCFG][7:2]};
        c.frac_en = c.bw[DSM_BIT];
        c.ref_double = (c.mode == MODE_SYN) | r[R_REFCFG][DBL_BIT];
        c.use_upper_in = c.mode[1];
        c.lower_loop_en = (c.mode == MODE_LB);
        c.drv_en = r[R_MODE][OE_BIT];
        c.lvds_sel = r[R_OUTCFG][QTYPE_BIT];
        return c;
    endfunction : cfg_of

    // Returns {flag, count}; a seen edge clears both, the third missing edge sets the flag.
    function automatic logic [2:0] miss_count(input logic [1:0] cnt, input logic flag,
                                              input logic seen, input logic fb);
        if (seen) begin
            return 3'h0;
        end
        if (fb && cnt == MISS_LIMIT - 2'h1) begin
            return {1'b1, cnt};
        end
        if (fb) begin
            return {flag, cnt + 2'h1};
        end
        return {flag, cnt};
    endfunction : miss_count
endpackage : pll_cfg_pkg

// ---- src/i2c_link_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface i2c_link_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    // Open-drain wires: any enabled driver presenting a low pulls the line low.
    assign scl = ~(scl_oe & ~scl_o);
    assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

    modport master (output scl_o, scl_oe, sda_m_o, sda_m_oe, input scl, sda);
    modport slave (output sda_s_o, sda_s_oe, input scl, sda);
endinterface : i2c_link_if
`default_nettype wire

// ---- src/pll_cfg_slave.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_slave
    import pll_cfg_pkg::*;
#(
    parameter logic [1:0] ADDR_LOW = 2'h0
)
(
    input  wire logic mclk,
    input  wire logic reset_n,
    i2c_link_if.slave link,
    input  wire logic ref_edge,
    input  wire logic fb_upper_edge,
    input  wire logic fb_lower_edge,
    input  wire logic in_edge,
    input  wire logic freq_locked,
    output logic      lock,
    output logic      reference_fault_flag,
    output logic      input_clock_fault_flag,
    output logic      holdover,
    output logic      free_run,
    output logic      phase_frozen,
    output cfg_type   cfg
);
    typedef enum logic [9:0] {
        S_IDLE = 10'h001,
        S_ADDR = 10'h002,
        S_AACK = 10'h004,
        S_REG  = 10'h008,
        S_RACK = 10'h010,
        S_WDAT = 10'h020,
        S_WACK = 10'h040,
        S_RDAT = 10'h080,
        S_MACK = 10'h100,
        S_SKIP = 10'h200
    } slave_st_type;

    typedef struct packed {
        slave_st_type     st;
        logic             scl_q;
        logic             sda_q;
        logic             rw;
        logic             nack;
        logic             sda_oe;
        logic [3:0]       cnt;
        logic [7:0]       sh;
        logic [7:0]       ptr;
        logic [23:0][7:0] regs;
        logic [1:0]       rcnt;
        logic [1:0]       ccnt;
        logic             lock;
        logic             rfault;
        logic             cfault;
        logic             hold;
        logic             free;
        logic             frozen;
        cfg_type          cfg;
    } slave_type;

    slave_type  s_r;
    slave_type  s_nxt;
    logic       rise;
    logic       fall;
    logic       fb_sel;
    logic [7:0] status;
    logic [7:0] rd_now;
    logic [2:0] rmiss;
    logic [2:0] cmiss;
    logic [4:0] idx;

    always_comb begin
        s_nxt = s_r;
        rise = link.scl & ~s_r.scl_q;
        fall = ~link.scl & s_r.scl_q;
        idx = s_r.ptr[4:0];
        status = 8'h00;
        status[ST_HOLD_BIT] = s_r.hold | s_r.free;
        status[ST_CLK_BIT] = s_r.cfault;
        status[ST_REF_BIT] = s_r.rfault;
        status[ST_LOCK_BIT] = s_r.lock;
        // Unmapped pointer positions read as zero.
        if (s_r.ptr == REG_STATUS) begin
            rd_now = status;
        end else if (s_r.ptr < REG_LAST) begin
            rd_now = s_r.regs[idx];
        end else begin
            rd_now = 8'h00;
        end
        s_nxt.scl_q = link.scl;
        s_nxt.sda_q = link.sda;
        if (link.scl && s_r.scl_q && s_r.sda_q && !link.sda) begin
            s_nxt.st = S_ADDR;
            s_nxt.cnt = 4'h0;
            s_nxt.sda_oe = 1'b0;
        end else if (link.scl && s_r.scl_q && !s_r.sda_q && link.sda) begin
            s_nxt.st = S_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else if (rise) begin
            if (s_r.st inside {S_ADDR, S_REG, S_WDAT}) begin
                s_nxt.sh = {s_r.sh[6:0], link.sda};
                s_nxt.cnt = s_r.cnt + 4'h1;
            end
            if (s_r.st == S_MACK) begin
                s_nxt.nack = link.sda;
            end
        end else if (fall) begin
            case (s_r.st)
                S_ADDR: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.cnt = 4'h0;
                        if (s_r.sh[7:1] == {ADDR_HI, ADDR_LOW}) begin
                            s_nxt.sda_oe = 1'b1;
                            s_nxt.rw = s_r.sh[0];
                            s_nxt.st = S_AACK;
                        end else begin
                            s_nxt.st = S_SKIP;
                        end
                    end
                end
                S_AACK: begin
                    if (s_r.rw) begin
                        s_nxt.sh = rd_now;
                        s_nxt.sda_oe = ~rd_now[7];
                        s_nxt.cnt = 4'h0;
                        s_nxt.st = S_RDAT;
                    end else begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = S_REG;
                    end
                end
                S_REG: begin
                    if (s_r.cnt == 4'h8) begin
                        s_nxt.ptr = s_r.sh;
                        s_nxt.cnt = 4'h0;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = S_RACK;
                    end
                end
                S_RACK, S_WACK: begin
                    s_nxt.sda_oe = 1'b0;
                    s_nxt.st = S_WDAT;
                end
                S_WDAT: begin
                    if (s_r.cnt == 4'h8) begin
                        if (s_r.ptr < REG_LAST) begin
                            s_nxt.regs[idx] = (s_r.sh & REG_WMASK[idx])
                                            | (s_r.regs[idx] & ~REG_WMASK[idx]);
                        end
                        s_nxt.ptr = s_r.ptr + 8'h1;
                        s_nxt.cnt = 4'h0;
                        s_nxt.sda_oe = 1'b1;
                        s_nxt.st = S_WACK;
                    end
                end
                S_RDAT: begin
                    if (s_r.cnt == 4'h7) begin
                        s_nxt.ptr = s_r.ptr + 8'h1;
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st = S_MACK;
                    end else begin
                        s_nxt.sh = {s_r.sh[6:0], 1'b0};
                        s_nxt.sda_oe = ~s_r.sh[6];
                        s_nxt.cnt = s_r.cnt + 4'h1;
                    end
                end
                S_MACK: begin
                    if (s_r.nack) begin
                        s_nxt.st = S_SKIP;
                    end else begin
                        s_nxt.sh = rd_now;
                        s_nxt.sda_oe = ~rd_now[7];
                        s_nxt.cnt = 4'h0;
                        s_nxt.st = S_RDAT;
                    end
                end
                default: begin
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end
        // alarms ignore the mode except for feedback choice.
        fb_sel = (s_r.cfg.mode == MODE_LB) ? fb_lower_edge : fb_upper_edge;
        rmiss = miss_count(s_r.rcnt, s_r.rfault, ref_edge, fb_upper_edge);
        cmiss = miss_count(s_r.ccnt, s_r.cfault, in_edge, fb_sel);
        {s_nxt.rfault, s_nxt.rcnt} = rmiss;
        {s_nxt.cfault, s_nxt.ccnt} = cmiss;
        s_nxt.lock = freq_locked;
        s_nxt.hold = s_r.cfault & (s_r.cfg.mode == MODE_LB);
        s_nxt.free = s_r.cfault & s_r.cfg.mode[1];
        s_nxt.frozen = s_r.cfault & (s_r.cfg.mode != MODE_SYN);
        s_nxt.cfg = cfg_of(s_r.regs);
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_r <= '{st: S_IDLE, scl_q: 1'b1, sda_q: 1'b1, regs: REG_DEFAULT,
                     cfg: cfg_of(REG_DEFAULT), default: '0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // The slave only ever pulls low, so its data value is a constant low.
    assign link.sda_s_o = 1'b0;
    assign link.sda_s_oe = s_r.sda_oe;
    assign lock = s_r.lock;
    assign reference_fault_flag = s_r.rfault;
    assign input_clock_fault_flag = s_r.cfault;
    assign holdover = s_r.hold;
    assign free_run = s_r.free;
    assign phase_frozen = s_r.frozen;
    assign cfg = s_r.cfg;
endmodule : pll_cfg_slave
`default_nettype wire

// ---- src/i2c_cfg_master.sv ----
`timescale 1ns/1ps
`default_nettype none
module i2c_cfg_master
    import pll_cfg_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset_n,
    i2c_link_if.master       link,
    input  wire logic        cmd_go,
    input  wire logic        cmd_read,
    input  wire logic [6:0]  cmd_dev,
    input  wire logic [7:0]  cmd_reg,
    input  wire logic [4:0]  cmd_len,
    input  wire logic [7:0]  wr_data,
    output logic             wr_take,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    output logic             busy,
    output logic             ack_err
);
    typedef enum logic [3:0] {
        M_IDLE  = 4'h1,
        M_START = 4'h2,
        M_BIT   = 4'h4,
        M_STOP  = 4'h8
    } master_st_type;

    typedef struct packed {
        master_st_type st;
        logic [1:0]    q;
        logic [7:0]    tick;
        logic [3:0]    bitn;
        logic [7:0]    tx;
        logic [7:0]    rx;
        logic [1:0]    stage;
        logic          rd;
        logic [6:0]    dev;
        logic [7:0]    regaddr;
        logic [4:0]    left;
        logic          scl_oe;
        logic          sda_oe;
        logic          wr_take;
        logic          rd_valid;
        logic [7:0]    rd_data;
        logic          busy;
        logic          err;
    } master_type;

    master_type m_r;
    master_type m_nxt;
    logic       tx_mode;

    always_comb begin
        m_nxt = m_r;
        m_nxt.wr_take = 1'b0;
        m_nxt.rd_valid = 1'b0;
        tx_mode = !(m_r.stage == 2'h3 && m_r.rd);
        if (m_r.st == M_IDLE) begin
            if (cmd_go) begin
                m_nxt = '{st: M_START, busy: 1'b1, rd: cmd_read, dev: cmd_dev,
                          regaddr: cmd_reg, left: cmd_len, tx: {cmd_dev, 1'b0},
                          rd_data: m_r.rd_data, default: '0};
            end
        end else if (m_r.tick != SCL_QTR_CYC - 8'h1) begin
            m_nxt.tick = m_r.tick + 8'h1;
        end else begin
            m_nxt.tick = 8'h0;
            m_nxt.q = m_r.q + 2'h1;
            case (m_r.st)
                M_START: begin
                    case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b0;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b1;
                        default: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.bitn = 4'h0;
                            m_nxt.st = M_BIT;
                        end
                    endcase
                end
                M_BIT: begin
                    case (m_r.q)
                        2'h0: begin
                            if (m_r.bitn < 4'h8) begin
                                m_nxt.sda_oe = tx_mode & ~m_r.tx[7];
                            end else begin
                                // Acknowledge every read byte but the last one.
                                m_nxt.sda_oe = !tx_mode && m_r.left != 5'h1;
                            end
                        end
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: begin
                            if (m_r.bitn < 4'h8) begin
                                m_nxt.rx = {m_r.rx[6:0], link.sda};
                            end else if (tx_mode) begin
                                m_nxt.err = link.sda;
                            end
                        end
                        default: begin
                            m_nxt.scl_oe = 1'b1;
                            m_nxt.bitn = m_r.bitn + 4'h1;
                            m_nxt.tx = {m_r.tx[6:0], 1'b0};
                            if (m_r.bitn == 4'h8) begin
                                m_nxt.bitn = 4'h0;
                                if (tx_mode && m_r.err) begin
                                    m_nxt.st = M_STOP;
                                end else begin
                                    case (m_r.stage)
                                        2'h0: begin
                                            m_nxt.stage = 2'h1;
                                            m_nxt.tx = m_r.regaddr;
                                        end
                                        2'h1: begin
                                            if (m_r.left == 5'h0) begin
                                                m_nxt.st = M_STOP;
                                            end else if (m_r.rd) begin
                                                m_nxt.stage = 2'h2;
                                                m_nxt.tx = {m_r.dev, 1'b1};
                                                m_nxt.st = M_START;
                                            end else begin
                                                m_nxt.stage = 2'h3;
                                                m_nxt.tx = wr_data;
                                                m_nxt.wr_take = 1'b1;
                                            end
                                        end
                                        2'h2: m_nxt.stage = 2'h3;
                                        default: begin
                                            if (m_r.rd) begin
                                                m_nxt.rd_data = m_r.rx;
                                                m_nxt.rd_valid = 1'b1;
                                            end
                                            m_nxt.left = m_r.left - 5'h1;
                                            if (m_r.left == 5'h1) begin
                                                m_nxt.st = M_STOP;
                                            end else if (!m_r.rd) begin
                                                m_nxt.tx = wr_data;
                                                m_nxt.wr_take = 1'b1;
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
                M_STOP: begin
                    case (m_r.q)
                        2'h0: m_nxt.sda_oe = 1'b1;
                        2'h1: m_nxt.scl_oe = 1'b0;
                        2'h2: m_nxt.sda_oe = 1'b0;
                        default: begin
                            m_nxt.busy = 1'b0;
                            m_nxt.st = M_IDLE;
                        end
                    endcase
                end
                default: m_nxt.st = M_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            m_r <= '{st: M_IDLE, default: '0};
        end else begin
            m_r <= m_nxt;
        end
    end

    assign link.scl_o = 1'b0;
    assign link.sda_m_o = 1'b0;
    assign link.scl_oe = m_r.scl_oe;
    assign link.sda_m_oe = m_r.sda_oe;
    assign wr_take = m_r.wr_take;
    assign rd_data = m_r.rd_data;
    assign rd_valid = m_r.rd_valid;
    assign busy = m_r.busy;
    assign ack_err = m_r.err;
endmodule : i2c_cfg_master
`default_nettype wire

// ---- tb/pll_cfg_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module pll_cfg_assertions
    import pll_cfg_pkg::*;
(
    input wire logic    mclk,
    input wire logic    reset_n,
    input wire logic    scl,
    input wire logic    sda,
    input wire logic    sda_s_oe,
    input wire logic    ref_edge,
    input wire logic    in_edge,
    input wire logic    fb_upper_edge,
    input wire logic    freq_locked,
    input wire logic    lock,
    input wire logic    reference_fault_flag,
    input wire logic    input_clock_fault_flag,
    input wire logic    phase_frozen,
    input wire cfg_type cfg
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_lock; $rose(freq_locked) |=> lock; endproperty
    a_lock: assert property (p_lock) else $error("lock late");
    property p_unlock; $fell(freq_locked) |=> !lock; endproperty
    a_unlock: assert property (p_unlock) else $error("lock kept");
    property p_rclr; ref_edge |=> !reference_fault_flag; endproperty
    a_rclr: assert property (p_rclr) else $error("ref fault kept");
    property p_rset; $rose(reference_fault_flag) |-> $past(fb_upper_edge); endproperty
    a_rset: assert property (p_rset) else $error("ref fault early");
    property p_iclr; in_edge |=> !input_clock_fault_flag; endproperty
    a_iclr: assert property (p_iclr) else $error("input fault kept");
    property p_frz;
        $rose(input_clock_fault_flag) && cfg.mode != MODE_SYN |=> phase_frozen;
    endproperty
    a_frz: assert property (p_frz) else $error("phase not frozen");
    property p_drv; $rose(sda_s_oe) |-> !scl && !$past(scl) && $past(scl, 2); endproperty
    a_drv: assert property (p_drv) else $error("drive with clock high");
    property p_rel; $fell(sda_s_oe) |-> !scl && !$past(scl) && $past(scl, 2); endproperty
    a_rel: assert property (p_rel) else $error("release with clock high");
    property p_stop; scl && $rose(sda) |=> !sda_s_oe [*4]; endproperty
    a_stop: assert property (p_stop) else $error("drive after stop");
endmodule : pll_cfg_assertions
`default_nettype wire

// ---- tb/tb_pll_config_port_and_alarms.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_pll_config_port_and_alarms;
    import pll_cfg_pkg::*;
    logic mclk = 1'b0, reset_n = 1'b0, cmd_go = 1'b0, cmd_read = 1'b0, freq_locked = 1'b0;
    logic ref_edge = 1'b0, fb_upper_edge = 1'b0, fb_lower_edge = 1'b0, in_edge = 1'b0;
    logic [6:0]  cmd_dev = 7'h00;
    logic [7:0]  cmd_reg = 8'h00, wr_data = 8'h00, rd_data, w18, w20;
    logic [4:0]  cmd_len = 5'h00;
    logic        wr_take, rd_valid, busy, ack_err, lock, holdover, free_run, phase_frozen;
    logic        reference_fault_flag, input_clock_fault_flag;
    cfg_type     cfg;
    int          miscompares = 0, comparisons = 0;
    logic [15:0] rnd = 16'h0001;
    logic [7:0]  wq[$], rq[$], want[6];
    logic [7:0]  codes[4] = '{8'h02, 8'h0a, 8'h0d, 8'hff};
    i2c_link_if i2c_link_if_inst ();
    i2c_cfg_master i2c_cfg_master_inst (.mclk, .reset_n, .link(i2c_link_if_inst.master), .cmd_go,
        .cmd_read, .cmd_dev, .cmd_reg, .cmd_len, .wr_data, .wr_take, .rd_data, .rd_valid, .busy,
        .ack_err);
    pll_cfg_slave #(.ADDR_LOW(2'h2)) pll_cfg_slave_inst (.mclk, .reset_n,
        .link(i2c_link_if_inst.slave), .ref_edge, .fb_upper_edge, .fb_lower_edge, .in_edge,
        .freq_locked, .lock, .reference_fault_flag, .input_clock_fault_flag, .holdover, .free_run,
        .phase_frozen, .cfg);
    pll_cfg_assertions pll_cfg_assertions_inst (.mclk, .reset_n, .scl(i2c_link_if_inst.scl),
        .sda(i2c_link_if_inst.sda), .sda_s_oe(i2c_link_if_inst.sda_s_oe), .ref_edge, .in_edge,
        .fb_upper_edge, .freq_locked, .lock, .reference_fault_flag, .input_clock_fault_flag,
        .phase_frozen, .cfg);
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    function automatic logic [10:0] ratio(input logic [10:0] c);
        return (c < 11'h3) ? 11'h2 : ((c < 11'h6) ? c : (c & 11'h7fe));
    endfunction : ratio
    task automatic report_and_stop();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic xfer(input logic rd, input logic [6:0] dev, input logic [7:0] rg, input int n);
        int i, t;
        i = 0;
        rq.delete();
        @(posedge mclk);
        {cmd_read, cmd_dev, cmd_reg, cmd_len} <= {rd, dev, rg, 5'(n)};
        wr_data <= wq[0];
        cmd_go <= 1'b1;
        @(posedge mclk);
        cmd_go <= 1'b0;
        for (t = 0; t < 40000 && (t < 2 || busy); t++) begin
            @(negedge mclk);
            if (rd_valid) begin
                rq.push_back(rd_data);
            end
            if (wr_take) begin
                i++;
                @(posedge mclk);
                wr_data <= wq[i % wq.size()];
            end
        end
        if (t == 40000) begin
            miscompares++;
            report_and_stop();
        end
    endtask : xfer
    task automatic pulse(input logic [3:0] m, input int n);
        repeat (n) begin
            @(posedge mclk);
            {ref_edge, fb_upper_edge, fb_lower_edge, in_edge} <= m;
            @(posedge mclk);
            {ref_edge, fb_upper_edge, fb_lower_edge, in_edge} <= 4'h0;
        end
        @(negedge mclk);
        @(negedge mclk);
    endtask : pulse
    initial begin
        forever #25 mclk = ~mclk;
    end
    initial begin
        repeat (8) @(posedge mclk);
        reset_n <= 1'b1;
        @(negedge mclk);
        chk({cfg.mode, cfg.drv_en, cfg.out_ratio}, {MODE_LB, 1'b0, 11'h2});
        wq = '{8'h55};
        xfer(1'b0, 7'h6d, 8'h10, 1);
        chk({ack_err, cfg.out_ratio}, {1'b1, 11'h2});
        for (int k = 0; k < 4; k++) begin
            repeat (16) rnd = lfsr(rnd);
            // Corner bits flip with k so enable and standard bits see both values; the fraction bit flips with k[0] as well.
            w18 = rnd[7:0] ^ {2'h0, k[0], 4'h0, k[1]};
            w20 = {k[1:0], rnd[13:8] ^ {3'h0, k[0], 2'h0}};
            wq = '{codes[k], rnd[15:8], w18, rnd[15:8], w20};
            xfer(1'b0, 7'h6e, 8'h10, 5);
            chk({ack_err, cfg.mode}, {1'b0, k[1:0]});
            chk(cfg.out_ratio, ratio({4'h0, codes[k][7:1]}));
            chk({cfg.lvds_sel, cfg.drv_en}, {w18[0], w20[2]});
            chk(cfg.frac_en, w18[5]);
            chk(cfg.ref_double, k == 1);
            chk(cfg.use_upper_in, k > 1);
            chk(cfg.lower_loop_en, k == 0);
            chk({cfg.out_ratio >= 11'h2, cfg.out_ratio <= 11'h7fe}, 2'h3);
            pulse((k == 0) ? 4'h2 : 4'h4, 3);
            chk({reference_fault_flag, input_clock_fault_flag}, {k != 0, 1'b1});
            chk({holdover, free_run, phase_frozen}, {k == 0, k > 1, k != 1});
            pulse(4'h9, 1);
            chk({reference_fault_flag, input_clock_fault_flag}, 2'h0);
        end
        @(posedge mclk);
        freq_locked <= 1'b1;
        pulse(4'h4, 3);
        xfer(1'b1, 7'h6e, 8'h12, 6);
        want = '{w18 & 8'hfd, 8'h00, (w20 & 8'hc4) | 8'h10, 8'h60, 8'ha1, 8'h5c};
        foreach (want[j]) chk(rq[j], want[j]);
        chk(lock, 1'b1);
        @(posedge mclk);
        freq_locked <= 1'b0;
        repeat (3) @(negedge mclk);
        chk(lock, 1'b0);
        report_and_stop();
    end
endmodule : tb_pll_config_port_and_alarms
`default_nettype wire
